//--- verif/lmsm_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lmsm_monitor_properties (
    input wire aclk,
    input wire aresetn,
    input wire status_point,
    input wire renew_valid,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire trig_link_good,
    input wire trig_link_fail,
    input wire trig_member_mismatch,
    input wire trig_member_missing,
    input wire trig_member_gained,
    input wire trig_member_lost,
    input wire trig_data_renewed
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // the trigger lands on the edge right after the start point
    sequence s_point;
        $past(status_point);
    endsequence
    // the write executes one edge after both halves are taken, the answer shows after that
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
            |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_good_pulse;
        trig_link_good |=> !trig_link_good;
    endproperty
    a_good_pulse: assert property (p_good_pulse) else $error("good trigger too long");
    property p_fail_at_point;
        trig_link_fail |-> s_point;
    endproperty
    a_fail_at_point: assert property (p_fail_at_point) else $error("fail trigger off point");
    property p_group_at_point;
        trig_member_mismatch || trig_member_missing |-> s_point;
    endproperty
    a_group_at_point: assert property (p_group_at_point) else $error("group trigger stray");
    property p_change_at_point;
        trig_member_gained || trig_member_lost |-> s_point;
    endproperty
    a_change_at_point: assert property (p_change_at_point) else $error("change trigger stray");
    property p_renew_trig;
        trig_data_renewed |-> $past(renew_valid);
    endproperty
    a_renew_trig: assert property (p_renew_trig) else $error("renew trigger stray");
endmodule // lmsm_monitor_properties
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsm_consts.vh"
module tb;
    logic aclk = 0, aresetn = 0, sp = 0, frz = 0, rv = 0, rclr = 0;
    logic [63:0] lfs = 0, own = 0;
    logic [5:0] stn = 0, rb = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] ws = 4'hF;
    logic [6:0] trg, seen = 0;
    logic tc = 0;
    int n_mismatch = 0, cmp_count = 0, i;
    logic [15:0] st_tab [7] = '{16'h0030, 16'h0030, 16'h4030, 0, 0, 0, 16'h8000};
    logic mf_tab [7] = '{0, 0, 1, 1, 1, 1, 0};
    always #10 aclk = ~aclk;
    // sticky record of trigger pulses; reset keeps unknowns before reset out of it
    always @(posedge aclk) seen <= (tc || !aresetn) ? 7'h00 : seen | trg;
    lmsm_monitor i_dut (.aclk(aclk), .aresetn(aresetn), .status_point(sp), .freeze_hold(frz),
        .link_flag_set(lfs), .own_block_mask(own), .station_number(stn), .renew_valid(rv),
        .renew_block(rb), .renewal_clear(rclr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trig_link_good(trg[0]), .trig_link_fail(trg[1]), .trig_member_mismatch(trg[2]),
        .trig_member_missing(trg[3]), .trig_member_gained(trg[4]), .trig_member_lost(trg[5]),
        .trig_data_renewed(trg[6]));
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 0;
            if (wready && wvalid) wvalid <= 0;
        end while (!bvalid);
        bready <= 0; r = bresp;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 0;
        end while (!rvalid);
        rready <= 0; d = rdata; r = rresp;
    endtask
    task point;
        @(posedge aclk) sp <= 1;
        @(posedge aclk) sp <= 0;
        repeat (3) @(posedge aclk);
    endtask
    task tclr;
        @(posedge aclk) tc <= 1;
        @(posedge aclk) tc <= 0;
    endtask
    task t_regs;
        // an empty link group counts as all up, so link good sets right after reset
        rd(`LMSM_OFF_STATUS); chk("status reset", d, 32'h1000);
        for (i = 0; i < 6; i++) begin
            wr(i * 4, 32'hA5C3_0000 | i); rd(i * 4); chk("rw word", d, 32'hA5C3_0000 | i);
        end
        @(posedge aclk) ws <= 4'h1;
        wr(`LMSM_OFF_LGM_LO, 32'h0000_00FF); rd(`LMSM_OFF_LGM_LO);
        chk("strobe", d, 32'hA5C3_00FF);
        @(posedge aclk) ws <= 4'hF;
        wr(`LMSM_OFF_MF_LO, 32'hFFFF_FFFF); chk("ro resp", r, `LMSM_RESP_OKAY);
        rd(`LMSM_OFF_MF_LO); chk("ro kept", d, 0);
        wr(8'h38, 1); chk("bad wr", r, `LMSM_RESP_SLVERR);
        wr(8'h01, 1); chk("unaligned", r, `LMSM_RESP_SLVERR);
        rd(8'h38); chk("bad rd resp", r, `LMSM_RESP_SLVERR);
        chk("bad rd data", d, 0);
    endtask
    task t_member;
        wr(`LMSM_OFF_MGM_LO, 32'h20); wr(`LMSM_OFF_MGM_HI, 0);
        @(posedge aclk) lfs <= 64'h20;
        for (i = 0; i < 7; i++) begin
            // link drops after the third point, flag still set until the next clear
            if (i == 3) @(posedge aclk) lfs <= 0;
            point;
            rd(`LMSM_OFF_STATUS); chk("member status", d & 32'hC030, st_tab[i]);
            rd(`LMSM_OFF_MF_LO); chk("member flag", d[5], mf_tab[i]);
        end
        chk("trig off", seen, 0);
    endtask
    task t_link;
        wr(`LMSM_OFF_LGM_LO, 8); wr(`LMSM_OFF_LGM_HI, 0); wr(`LMSM_OFF_TRIG_EN, 32'h7F);
        @(posedge aclk) own <= 1;
        point;
        rd(`LMSM_OFF_LF_LO); chk("link flags", d, 1);
        // station 3 was silent through the ended cycle, so fail is captured here
        rd(`LMSM_OFF_STATUS); chk("not yet good", d & 32'h3000, 32'h2000);
        chk("trig point", seen, 7'h0E);
        @(posedge aclk) lfs <= 8;
        @(posedge aclk) lfs <= 0;
        repeat (3) @(posedge aclk);
        rd(`LMSM_OFF_STATUS); chk("good", d & 32'h3000, 32'h3000);
        chk("trig good", seen, 7'h0F);
        tclr;
        @(posedge aclk) frz <= 1;
        point;
        rd(`LMSM_OFF_STATUS); chk("frozen good", d & 32'h3000, 32'h1000);
        @(posedge aclk) frz <= 0;
        point;
        rd(`LMSM_OFF_STATUS); chk("fail", d & 32'h3000, 32'h2000);
        chk("trig fail", seen, 7'h12);
        @(posedge aclk) lfs <= 8;
        @(posedge aclk) lfs <= 0;
        point;
        rd(`LMSM_OFF_STATUS); chk("fail cleared", d & 32'h3000, 0);
        chk("trig again", seen, 7'h13);
    endtask
    task renew(input logic [5:0] b);
        @(posedge aclk) begin rv <= 1; rb <= b; end
        @(posedge aclk) rv <= 0;
    endtask
    task t_renew;
        tclr;
        @(posedge aclk) stn <= 7;
        wr(`LMSM_OFF_RCE_LO, 32'h84); wr(`LMSM_OFF_RCE_HI, 0);
        renew(7); renew(9);
        rd(`LMSM_OFF_RF_LO); chk("own or off", d, 0);
        chk("no renew trig", seen, 0);
        renew(2);
        rd(`LMSM_OFF_RF_LO); chk("renew flags", d, 4);
        rd(`LMSM_OFF_STATUS); chk("renewed", d[11], 1);
        chk("renew trig", seen, 7'h40);
        @(posedge aclk) rclr <= 1;
        @(posedge aclk) rclr <= 0;
        rd(`LMSM_OFF_RF_LO); chk("renew clr", d, 0);
        rd(`LMSM_OFF_STATUS); chk("renewed clr", d[11], 0);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        t_regs; t_member; t_link; t_renew;
        final_report;
    end
    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        final_report;
    end
endmodule // tb
bind lmsm_monitor lmsm_monitor_properties i_props (.aclk(aclk), .aresetn(aresetn),
    .status_point(status_point), .renew_valid(renew_valid), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trig_link_good(trig_link_good),
    .trig_link_fail(trig_link_fail), .trig_member_mismatch(trig_member_mismatch),
    .trig_member_missing(trig_member_missing), .trig_member_gained(trig_member_gained),
    .trig_member_lost(trig_member_lost), .trig_data_renewed(trig_data_renewed));
`default_nettype wire

//--- verilog/lmsm_consts.vh
// How it works
// - software-written 64-bit link group mask picks the stations to watch.
// - after the start-point clear, link good sets once all selected link flags are one.
// - link fail when a selected link flag is still zero just before the next start point.
// - link good is status bit 12, link fail is status bit 13, active high.
// - link good clears at each start point unless freezing holds it.
// - link fail captures the ended cycle's result at the start point and holds it a cycle.
// - link good and link fail can each raise an interrupt trigger.
// - 64 member flags, bit n for station n, judged at the start point.
// - member flag sets after link seen established at three successive start points.
// - member flag clears after link seen missing at three successive start points.
// - software-written 64-bit member group mask, one bit per member flag.
// - once per cycle check whether member group mask and member flags differ.
// - same check flags a zero member flag under a one mask bit.
// - mismatch is status bit 4, missing member is status bit 5, active high.
// - mismatch and missing bits update at each start point.
// - enabled trigger when status bit 4 or 5 newly rises.
// - bit 14 on any member flag rise, bit 15 on any fall, mask ignored.
// - gained and lost bits update at each start point and can raise triggers.
// - 64-bit renewal check enable, bit n enables change detection for block n.
// - a change in an enabled block sets data renewed, status bit 11.
// - a 64-bit renewal flag register marks each changed block.
// - renewal in an enabled block can raise an interrupt trigger.
// - link flags clear at each start point, own blocks always held at one.
// - renewal detection only for enabled blocks and never for the own block.
`ifndef LMSM_CONSTS_VH
`define LMSM_CONSTS_VH
`define LMSM_ADDR_W 8
`define LMSM_OFF_LGM_LO 8'h00
`define LMSM_OFF_LGM_HI 8'h04
`define LMSM_OFF_MGM_LO 8'h08
`define LMSM_OFF_MGM_HI 8'h0C
`define LMSM_OFF_RCE_LO 8'h10
`define LMSM_OFF_RCE_HI 8'h14
`define LMSM_OFF_STATUS 8'h18
`define LMSM_OFF_MF_LO 8'h1C
`define LMSM_OFF_MF_HI 8'h20
`define LMSM_OFF_RF_LO 8'h24
`define LMSM_OFF_RF_HI 8'h28
`define LMSM_OFF_LF_LO 8'h2C
`define LMSM_OFF_LF_HI 8'h30
`define LMSM_OFF_TRIG_EN 8'h34
`define LMSM_BIT_MISMATCH 4
`define LMSM_BIT_MISSING 5
`define LMSM_BIT_RENEWED 11
`define LMSM_BIT_LINK_GOOD 12
`define LMSM_BIT_LINK_FAIL 13
`define LMSM_BIT_GAINED 14
`define LMSM_BIT_LOST 15
`define LMSM_TEN_LINK_GOOD 0
`define LMSM_TEN_LINK_FAIL 1
`define LMSM_TEN_MISMATCH 2
`define LMSM_TEN_MISSING 3
`define LMSM_TEN_GAINED 4
`define LMSM_TEN_LOST 5
`define LMSM_TEN_RENEWED 6
`define LMSM_TEN_W 7
`define LMSM_HYST_LAST 2'h2
`define LMSM_RESP_OKAY 2'h0
`define LMSM_RESP_SLVERR 2'h2
`endif

//--- verilog/lmsm_monitor.v
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lmsm_consts.vh"

module lmsm_monitor #(
    parameter STATIONS = 64
) (
    input wire aclk,
    input wire aresetn,
    input wire status_point,
    input wire freeze_hold,
    input wire [STATIONS-1:0] link_flag_set,
    input wire [STATIONS-1:0] own_block_mask,
    input wire [5:0] station_number,
    input wire renew_valid,
    input wire [5:0] renew_block,
    input wire renewal_clear,
    input wire [`LMSM_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`LMSM_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg trig_link_good,
    output reg trig_link_fail,
    output reg trig_member_mismatch,
    output reg trig_member_missing,
    output reg trig_member_gained,
    output reg trig_member_lost,
    output reg trig_data_renewed
);

    function [31:0] lmsm_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            lmsm_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i])
                    lmsm_merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    function lmsm_mapped;
        input [`LMSM_ADDR_W-1:0] a;
        begin
            lmsm_mapped = (a[1:0] == 2'h0) && (a <= `LMSM_OFF_TRIG_EN);
        end
    endfunction

    reg [63:0] link_group_mask;
    reg [63:0] member_group_mask;
    reg [63:0] renewal_check_enable;
    reg [`LMSM_TEN_W-1:0] trig_enable;
    reg [63:0] link_flags;
    reg [63:0] member_flags;
    reg [63:0] renewal_flags;
    reg link_group_good;
    reg link_group_fail;
    reg member_group_mismatch;
    reg member_group_missing;
    reg member_gained;
    reg member_lost;
    reg data_renewed;

    reg [`LMSM_ADDR_W-1:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg [31:0] rd_word;
    wire wr_go;
    wire [63:0] next_member_flags;
    wire [63:0] hyst_mask;
    wire [63:0] own_full;
    wire [63:0] set_full;
    wire all_selected_up;
    wire renew_hit;
    wire [15:0] system_status;

    genvar g;

    generate
        if (STATIONS < 64) begin : g_pad
            assign own_full = {{(64-STATIONS){1'b0}}, own_block_mask};
            assign set_full = {{(64-STATIONS){1'b0}}, link_flag_set};
        end else begin : g_full
            assign own_full = own_block_mask[63:0];
            assign set_full = link_flag_set[63:0];
        end
    endgenerate

    // both halves of the write held and no response pending
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    assign all_selected_up = ((link_flags & link_group_mask) == link_group_mask);
    // own station's block is never watched for renewal
    assign renew_hit = renew_valid && renewal_check_enable[renew_block]
        && (renew_block != station_number);

    assign system_status = {member_lost, member_gained, link_group_fail, link_group_good,
        data_renewed, 5'h00, member_group_missing, member_group_mismatch, 4'h0};

    // per-station three-in-a-row hysteresis; the link flags sampled at the start
    // point still hold the whole ended cycle, before they are cleared
    generate
        for (g = 0; g < 64; g = g + 1) begin : g_member
            reg [1:0] streak;
            wire disagree;
            assign disagree = link_flags[g] != member_flags[g];
            assign hyst_mask[g] = disagree && (streak == `LMSM_HYST_LAST);
            assign next_member_flags[g] = member_flags[g] ^ hyst_mask[g];
            always @(posedge aclk) begin
                if (!aresetn) begin
                    streak <= 2'h0;
                end else if (status_point) begin
                    if (!disagree || hyst_mask[g])
                        streak <= 2'h0;
                    else
                        streak <= streak + 2'h1;
                end
            end
        end
    endgenerate

    // link flags and link group results
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_flags <= 64'h0000000000000000;
            link_group_good <= 1'b0;
            link_group_fail <= 1'b0;
        end else if (status_point) begin
            link_flags <= own_full;
            link_group_fail <= |(link_group_mask & ~link_flags);
            if (!freeze_hold)
                link_group_good <= 1'b0;
        end else begin
            link_flags <= link_flags | set_full | own_full;
            if (all_selected_up)
                link_group_good <= 1'b1;
        end
    end

    // member flags and member group results, all settled at the start point
    always @(posedge aclk) begin
        if (!aresetn) begin
            member_flags <= 64'h0000000000000000;
            member_group_mismatch <= 1'b0;
            member_group_missing <= 1'b0;
            member_gained <= 1'b0;
            member_lost <= 1'b0;
        end else if (status_point) begin
            member_flags <= next_member_flags;
            member_group_mismatch <= |(member_group_mask ^ member_flags);
            member_group_missing <= |(member_group_mask & ~member_flags);
            member_gained <= |(~member_flags & next_member_flags);
            member_lost <= |(member_flags & ~next_member_flags);
        end
    end

    // renewal flags: a hit in the clearing cycle survives the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            renewal_flags <= 64'h0000000000000000;
            data_renewed <= 1'b0;
        end else begin
            if (renewal_clear) begin
                renewal_flags <= 64'h0000000000000000;
                data_renewed <= 1'b0;
            end
            if (renew_hit) begin
                renewal_flags[renew_block] <= 1'b1;
                data_renewed <= 1'b1;
            end
        end
    end

    // interrupt triggers, one-cycle pulses gated by the enable register
    always @(posedge aclk) begin
        if (!aresetn) begin
            trig_link_good <= 1'b0;
            trig_link_fail <= 1'b0;
            trig_member_mismatch <= 1'b0;
            trig_member_missing <= 1'b0;
            trig_member_gained <= 1'b0;
            trig_member_lost <= 1'b0;
            trig_data_renewed <= 1'b0;
        end else begin
            trig_link_good <= trig_enable[`LMSM_TEN_LINK_GOOD] && !status_point
                && !link_group_good && all_selected_up;
            trig_link_fail <= trig_enable[`LMSM_TEN_LINK_FAIL] && status_point
                && |(link_group_mask & ~link_flags);
            trig_member_mismatch <= trig_enable[`LMSM_TEN_MISMATCH] && status_point
                && !member_group_mismatch
                && |(member_group_mask ^ member_flags);
            trig_member_missing <= trig_enable[`LMSM_TEN_MISSING] && status_point
                && !member_group_missing
                && |(member_group_mask & ~member_flags);
            trig_member_gained <= trig_enable[`LMSM_TEN_GAINED] && status_point
                && |(~member_flags & next_member_flags);
            trig_member_lost <= trig_enable[`LMSM_TEN_LOST] && status_point
                && |(member_flags & ~next_member_flags);
            trig_data_renewed <= trig_enable[`LMSM_TEN_RENEWED] && renew_hit;
        end
    end

    // write channel: address and data taken in either order or in the same cycle, one write at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LMSM_RESP_OKAY;
            wr_addr <= {`LMSM_ADDR_W{1'b0}};
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= lmsm_mapped(wr_addr) ? `LMSM_RESP_OKAY : `LMSM_RESP_SLVERR;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // software masks; read-only registers ignore writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_group_mask <= 64'h0000000000000000;
            member_group_mask <= 64'h0000000000000000;
            renewal_check_enable <= 64'h0000000000000000;
            trig_enable <= {`LMSM_TEN_W{1'b0}};
        end else if (wr_go) begin
            case (wr_addr)
                `LMSM_OFF_LGM_LO: link_group_mask[31:0] <=
                    lmsm_merge(link_group_mask[31:0], wr_data, wr_strb);
                `LMSM_OFF_LGM_HI: link_group_mask[63:32] <=
                    lmsm_merge(link_group_mask[63:32], wr_data, wr_strb);
                `LMSM_OFF_MGM_LO: member_group_mask[31:0] <=
                    lmsm_merge(member_group_mask[31:0], wr_data, wr_strb);
                `LMSM_OFF_MGM_HI: member_group_mask[63:32] <=
                    lmsm_merge(member_group_mask[63:32], wr_data, wr_strb);
                `LMSM_OFF_RCE_LO: renewal_check_enable[31:0] <=
                    lmsm_merge(renewal_check_enable[31:0], wr_data, wr_strb);
                `LMSM_OFF_RCE_HI: renewal_check_enable[63:32] <=
                    lmsm_merge(renewal_check_enable[63:32], wr_data, wr_strb);
                `LMSM_OFF_TRIG_EN: if (wr_strb[0])
                    trig_enable <= wr_data[`LMSM_TEN_W-1:0];
                default: trig_enable <= trig_enable;
            endcase
        end
    end

    always @* begin
        case (s_axi_araddr)
            `LMSM_OFF_LGM_LO: rd_word = link_group_mask[31:0];
            `LMSM_OFF_LGM_HI: rd_word = link_group_mask[63:32];
            `LMSM_OFF_MGM_LO: rd_word = member_group_mask[31:0];
            `LMSM_OFF_MGM_HI: rd_word = member_group_mask[63:32];
            `LMSM_OFF_RCE_LO: rd_word = renewal_check_enable[31:0];
            `LMSM_OFF_RCE_HI: rd_word = renewal_check_enable[63:32];
            `LMSM_OFF_STATUS: rd_word = {16'h0000, system_status};
            `LMSM_OFF_MF_LO: rd_word = member_flags[31:0];
            `LMSM_OFF_MF_HI: rd_word = member_flags[63:32];
            `LMSM_OFF_RF_LO: rd_word = renewal_flags[31:0];
            `LMSM_OFF_RF_HI: rd_word = renewal_flags[63:32];
            `LMSM_OFF_LF_LO: rd_word = link_flags[31:0];
            `LMSM_OFF_LF_HI: rd_word = link_flags[63:32];
            `LMSM_OFF_TRIG_EN: rd_word = {{(32-`LMSM_TEN_W){1'b0}}, trig_enable};
            default: rd_word = 32'h00000000;
        endcase
    end

    // read channel: data sampled at the address handshake
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LMSM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= lmsm_mapped(s_axi_araddr) ? `LMSM_RESP_OKAY : `LMSM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // lmsm_monitor
`default_nettype wire
